// ### hw/psw_pkg.sv
// Package for the scaler window and RAM power-gate timing register bank.
// Assumes a 32-bit register port with byte-address offsets.
package psw_pkg;
   localparam logic [19:0] ADDR_GATE_A = 20'h68060;
   localparam logic [19:0] ADDR_ORIGIN_A = 20'h68070;
   localparam logic [19:0] ADDR_EXTENT_A = 20'h68074;
   localparam logic [19:0] ADDR_GATE_B = 20'h68860;
   localparam logic [19:0] ADDR_ORIGIN_B = 20'h68870;
   localparam logic [19:0] ADDR_EXTENT_B = 20'h68874;
   localparam logic [31:0] GATE_RESET = 32'h00006453;
   localparam logic [31:0] WIN_RESET = 32'h00000000;
   localparam logic [31:0] GATE_MASK = 32'h0000eedb;
   localparam logic [31:0] WIN_MASK = 32'h1fff0fff;
   localparam int LATE_START_LSB = 13;
   localparam int MID_START_LSB = 9;
   localparam int LATE_GAP_LSB = 6;
   localparam int MID_GAP_LSB = 3;
   localparam int EARLY_GAP_LSB = 0;
   localparam int LEFT_LSB = 16;
   localparam int TOP_LSB = 0;
   localparam int STEP_CYCLES = 256;
   localparam int NUM_PIPES = 2;

   typedef struct packed {
      logic [2:0] late_start;
      logic [2:0] mid_start;
      logic [1:0] late_gap;
      logic [1:0] mid_gap;
      logic [1:0] early_gap;
   } psw_gate_s;

   typedef struct packed {
      logic [12:0] left;
      logic [11:0] top;
      logic [12:0] width;
      logic [11:0] height;
   } psw_win_s;

   typedef struct packed {
      logic [10:0] late_start_cyc;
      logic [10:0] mid_start_cyc;
      logic [9:0] late_gap_cyc;
      logic [9:0] mid_gap_cyc;
      logic [9:0] early_gap_cyc;
   } psw_gate_cyc_s;

   // Active codes after reset decode the first-stage default
   localparam psw_gate_s GATE_ACT_RESET = 12'h69b;
   localparam psw_win_s WIN_ACT_RESET = 50'h0;
   // Cycle view stays zero until the first transfer
   localparam psw_gate_cyc_s CYC_RESET = 52'h0;
endpackage : psw_pkg

// ### hw/psw_regs.sv
// Register bank for two scaler pipes: window origin, extent, RAM gating.
// Assumes one-cycle register writes/reads, and a vblank-start pulse per pipe.
`timescale 1ns/1ps
module psw_regs (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [19:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic [1:0] i_vblank_start,
   output logic [31:0] o_rdata,
   output logic o_rvalid,
   output logic [1:0] o_armed,
   output psw_pkg::psw_win_s o_win_a,
   output psw_pkg::psw_win_s o_win_b,
   output psw_pkg::psw_gate_s o_gate_a,
   output psw_pkg::psw_gate_s o_gate_b,
   output psw_pkg::psw_gate_cyc_s o_cyc_a,
   output psw_pkg::psw_gate_cyc_s o_cyc_b
);
   logic [31:0] gate_reg [psw_pkg::NUM_PIPES];
   logic [31:0] origin_reg [psw_pkg::NUM_PIPES];
   logic [31:0] extent_reg [psw_pkg::NUM_PIPES];
   logic [31:0] gate_next [psw_pkg::NUM_PIPES];
   logic [31:0] origin_next [psw_pkg::NUM_PIPES];
   logic [31:0] extent_next [psw_pkg::NUM_PIPES];
   logic [1:0] arm_reg;
   logic [1:0] arm_next;
   psw_pkg::psw_win_s win_reg [psw_pkg::NUM_PIPES];
   psw_pkg::psw_win_s win_next [psw_pkg::NUM_PIPES];
   psw_pkg::psw_gate_s act_reg [psw_pkg::NUM_PIPES];
   psw_pkg::psw_gate_s act_next [psw_pkg::NUM_PIPES];
   psw_pkg::psw_gate_cyc_s cyc_reg [psw_pkg::NUM_PIPES];
   psw_pkg::psw_gate_cyc_s cyc_next [psw_pkg::NUM_PIPES];
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;
   logic [31:0] pipe_rdata [psw_pkg::NUM_PIPES];

   function automatic psw_pkg::psw_gate_s unpack_gate(input logic [31:0] v);
      psw_pkg::psw_gate_s g;
      g.late_start = v[psw_pkg::LATE_START_LSB +: 3];
      g.mid_start = v[psw_pkg::MID_START_LSB +: 3];
      g.late_gap = v[psw_pkg::LATE_GAP_LSB +: 2];
      g.mid_gap = v[psw_pkg::MID_GAP_LSB +: 2];
      g.early_gap = v[psw_pkg::EARLY_GAP_LSB +: 2];
      return g;
   endfunction : unpack_gate

   // Codes scaled to cycles; 256 is a power of two so a shift suffices
   function automatic psw_pkg::psw_gate_cyc_s to_cycles(
      input psw_pkg::psw_gate_s g);
      psw_pkg::psw_gate_cyc_s c;
      c.late_start_cyc = 11'(g.late_start * psw_pkg::STEP_CYCLES);
      c.mid_start_cyc = 11'(g.mid_start * psw_pkg::STEP_CYCLES);
      c.late_gap_cyc = 10'(g.late_gap * psw_pkg::STEP_CYCLES);
      c.mid_gap_cyc = 10'(g.mid_gap * psw_pkg::STEP_CYCLES);
      c.early_gap_cyc = 10'(g.early_gap * psw_pkg::STEP_CYCLES);
      return c;
   endfunction : to_cycles

   genvar p;
   generate
      for (p = 0; p < psw_pkg::NUM_PIPES; p++) begin : g_pipe
         logic [19:0] base_gate;
         logic [19:0] base_org;
         logic [19:0] base_ext;
         logic hit_gate;
         logic hit_org;
         logic hit_ext;
         logic do_xfer;
         psw_pkg::psw_gate_s staged_gate;
         psw_pkg::psw_gate_cyc_s staged_cyc;

         assign base_gate = (p == 0) ? psw_pkg::ADDR_GATE_A :
                                       psw_pkg::ADDR_GATE_B;
         assign base_org = (p == 0) ? psw_pkg::ADDR_ORIGIN_A :
                                      psw_pkg::ADDR_ORIGIN_B;
         assign base_ext = (p == 0) ? psw_pkg::ADDR_EXTENT_A :
                                      psw_pkg::ADDR_EXTENT_B;

         // Decode shared by writes and readback of this pipe
         assign hit_gate = (i_addr == base_gate);
         assign hit_org = (i_addr == base_org);
         assign hit_ext = (i_addr == base_ext);

         // transfer only at vblank start while armed
         assign do_xfer = arm_reg[p] && i_vblank_start[p];
         assign staged_gate = unpack_gate(gate_reg[p]);
         assign staged_cyc = to_cycles(staged_gate);

         always_comb begin
            gate_next[p] = gate_reg[p];
            origin_next[p] = origin_reg[p];
            extent_next[p] = extent_reg[p];
            if (i_wr && hit_gate) begin
               gate_next[p] = i_wdata & psw_pkg::GATE_MASK;
            end
            if (i_wr && hit_org) begin
               origin_next[p] = i_wdata & psw_pkg::WIN_MASK;
            end
            if (i_wr && hit_ext) begin
               extent_next[p] = i_wdata & psw_pkg::WIN_MASK;
            end
         end

         always_ff @(posedge i_mclk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               gate_reg[p] <= psw_pkg::GATE_RESET;
               origin_reg[p] <= psw_pkg::WIN_RESET;
               extent_reg[p] <= psw_pkg::WIN_RESET;
            end else if (i_ce) begin
               gate_reg[p] <= gate_next[p];
               origin_reg[p] <= origin_next[p];
               extent_reg[p] <= extent_next[p];
            end
         end

         // extent write arms; set beats the vblank clear
         always_comb begin
            arm_next[p] = arm_reg[p];
            if (do_xfer) begin
               arm_next[p] = 1'b0;
            end
            if (i_wr && hit_ext) begin
               arm_next[p] = 1'b1;
            end
         end

         always_ff @(posedge i_mclk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               arm_reg[p] <= 1'b0;
            end else if (i_ce) begin
               arm_reg[p] <= arm_next[p];
            end
         end

         // Old values keep driving the banks until the transfer
         always_comb begin
            win_next[p] = win_reg[p];
            act_next[p] = act_reg[p];
            cyc_next[p] = cyc_reg[p];
            if (do_xfer) begin
               act_next[p].late_start = staged_gate.late_start;
               cyc_next[p].late_start_cyc = staged_cyc.late_start_cyc;
               act_next[p].mid_start = staged_gate.mid_start;
               cyc_next[p].mid_start_cyc = staged_cyc.mid_start_cyc;
               act_next[p].late_gap = staged_gate.late_gap;
               cyc_next[p].late_gap_cyc = staged_cyc.late_gap_cyc;
               act_next[p].mid_gap = staged_gate.mid_gap;
               cyc_next[p].mid_gap_cyc = staged_cyc.mid_gap_cyc;
               act_next[p].early_gap = staged_gate.early_gap;
               cyc_next[p].early_gap_cyc = staged_cyc.early_gap_cyc;
               // origin passed on with no rotation remap
               win_next[p].left = origin_reg[p][psw_pkg::LEFT_LSB +: 13];
               win_next[p].top = origin_reg[p][psw_pkg::TOP_LSB +: 12];
               win_next[p].width = extent_reg[p][psw_pkg::LEFT_LSB +: 13];
               win_next[p].height = extent_reg[p][psw_pkg::TOP_LSB +: 12];
            end
         end

         always_ff @(posedge i_mclk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               win_reg[p] <= psw_pkg::WIN_ACT_RESET;
               act_reg[p] <= psw_pkg::GATE_ACT_RESET;
               cyc_reg[p] <= psw_pkg::CYC_RESET;
            end else if (i_ce) begin
               win_reg[p] <= win_next[p];
               act_reg[p] <= act_next[p];
               cyc_reg[p] <= cyc_next[p];
            end
         end

         always_comb begin
            pipe_rdata[p] = 32'h00000000;
            if (hit_gate) begin
               pipe_rdata[p] = gate_reg[p];
            end
            if (hit_org) begin
               pipe_rdata[p] = origin_reg[p];
            end
            if (hit_ext) begin
               pipe_rdata[p] = extent_reg[p];
            end
         end
      end
   endgenerate

   // Pipes decode disjoint addresses, so an OR merges them
   always_comb begin
      rvalid_next = i_rd;
      rdata_next = 32'h00000000;
      if (i_rd) begin
         rdata_next = pipe_rdata[0] | pipe_rdata[1];
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_reg <= 32'h00000000;
         rvalid_reg <= 1'b0;
      end else if (i_ce) begin
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_rvalid = rvalid_reg;
   assign o_armed = arm_reg;
   assign o_win_a = win_reg[0];
   assign o_win_b = win_reg[1];
   assign o_gate_a = act_reg[0];
   assign o_gate_b = act_reg[1];
   assign o_cyc_a = cyc_reg[0];
   assign o_cyc_b = cyc_reg[1];
endmodule : psw_regs

// ### testbench/psw_regs_props.sv
// Checker for psw_regs: readback, arming and vblank transfer.
// Assumes it is bound to every psw_regs instance.
`timescale 1ns/1ps
module psw_regs_chk (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [19:0] i_addr,
   input wire logic [1:0] i_vblank_start,
   input wire logic [31:0] o_rdata,
   input wire logic o_rvalid,
   input wire logic [1:0] o_armed,
   input wire psw_pkg::psw_win_s o_win_a,
   input wire psw_pkg::psw_gate_s o_gate_a,
   input wire psw_pkg::psw_gate_cyc_s o_cyc_a
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   sequence s_wa;
      i_ce && i_wr && i_addr == psw_pkg::ADDR_EXTENT_A;
   endsequence
   sequence s_xa;
      i_ce && o_armed[0] && i_vblank_start[0];
   endsequence
   property p_rv;
      i_ce && i_rd |=> o_rvalid;
   endproperty
   a_rv: assert property (p_rv) else $error("no read answer");
   property p_rsv;
      i_ce && i_rd && i_addr == psw_pkg::ADDR_ORIGIN_A
         |=> (o_rdata & ~psw_pkg::WIN_MASK) == 32'h00000000;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits set");
   property p_arma;
      s_wa |=> o_armed[0];
   endproperty
   a_arma: assert property (p_arma) else $error("pipe a not armed");
   property p_armb;
      i_ce && i_wr && i_addr == psw_pkg::ADDR_EXTENT_B |=> o_armed[1];
   endproperty
   a_armb: assert property (p_armb) else $error("pipe b not armed");
   property p_hold;
      !i_vblank_start[0] |=> $stable(o_win_a);
   endproperty
   a_hold: assert property (p_hold) else $error("early update");
   property p_xfer;
      s_xa ##0 !i_wr |=> !o_armed[0];
   endproperty
   a_xfer: assert property (p_xfer) else $error("arm not cleared");
   property p_mid;
      s_xa |=> o_cyc_a.mid_start_cyc == {o_gate_a.mid_start, 8'h00};
   endproperty
   a_mid: assert property (p_mid) else $error("mid start cycles");
   property p_lgap;
      s_xa |=> o_cyc_a.late_gap_cyc == {o_gate_a.late_gap, 8'h00};
   endproperty
   a_lgap: assert property (p_lgap) else $error("late gap cycles");
   property p_mgap;
      s_xa |=> o_cyc_a.mid_gap_cyc == {o_gate_a.mid_gap, 8'h00};
   endproperty
   a_mgap: assert property (p_mgap) else $error("mid gap cycles");
   property p_egap;
      s_xa |=> o_cyc_a.early_gap_cyc == {o_gate_a.early_gap, 8'h00};
   endproperty
   a_egap: assert property (p_egap) else $error("early gap cycles");
   property p_late;
      s_xa |=> o_cyc_a.late_start_cyc == {o_gate_a.late_start, 8'h00};
   endproperty
   a_late: assert property (p_late) else $error("late start cycles");
endmodule : psw_regs_chk
bind psw_regs psw_regs_chk chk_u (.i_mclk, .i_rst_n, .i_ce, .i_wr, .i_rd,
   .i_addr, .i_vblank_start, .o_rdata, .o_rvalid, .o_armed, .o_win_a,
   .o_gate_a, .o_cyc_a);

// ### testbench/psw_regs_tb_top.sv
// Testbench for psw_regs: reset values, readback, arming, transfer.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps
module psw_regs_tb_top;
   typedef struct {logic [19:0] a; logic [31:0] d, r, e;} psw_row_s;
   logic i_mclk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_ce = 1'b1;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic [19:0] i_addr = 20'h00000;
   logic [31:0] i_wdata = 32'h00000000;
   logic [1:0] i_vblank_start = 2'h0;
   logic [31:0] o_rdata;
   logic o_rvalid;
   logic [1:0] o_armed;
   psw_pkg::psw_win_s o_win_a, o_win_b;
   psw_pkg::psw_gate_s o_gate_a, o_gate_b;
   psw_pkg::psw_gate_cyc_s o_cyc_a, o_cyc_b;
   int errors = 0;
   int n_compared = 0;
   psw_row_s rows [7];
   psw_regs dut_u (.i_mclk, .i_rst_n, .i_ce, .i_wr, .i_rd, .i_addr,
      .i_wdata, .i_vblank_start, .o_rdata, .o_rvalid, .o_armed, .o_win_a,
      .o_win_b, .o_gate_a, .o_gate_b, .o_cyc_a, .o_cyc_b);
   initial forever #20 i_mclk = ~i_mclk;
   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
   endtask : cmp
   task automatic wr(input logic [19:0] a, input logic [31:0] d);
      i_wr = 1'b1;
      i_addr = a;
      i_wdata = d;
      @(posedge i_mclk);
      #1 i_wr = 1'b0;
      // Idle edge keeps back-to-back strobes apart
      @(posedge i_mclk);
      #1;
   endtask : wr
   task automatic rd(input logic [19:0] a, input logic [31:0] e);
      i_rd = 1'b1;
      i_addr = a;
      @(posedge i_mclk);
      #1 i_rd = 1'b0;
      cmp({o_rvalid, o_rdata}, {1'b1, e});
      @(posedge i_mclk);
      #1;
   endtask : rd
   task automatic vb(input logic [1:0] v);
      i_vblank_start = v;
      @(posedge i_mclk);
      #1 i_vblank_start = 2'h0;
      @(posedge i_mclk);
      #1;
   endtask : vb
   task automatic print_verdict;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : print_verdict
   initial begin
      rows[0] = '{psw_pkg::ADDR_GATE_A, '1, 32'h6453, 32'heedb};
      rows[1] = '{psw_pkg::ADDR_ORIGIN_A, 32'hffff1234, 0, 32'h1fff0234};
      rows[2] = '{psw_pkg::ADDR_EXTENT_A, 32'h01230456, 0, 32'h01230456};
      rows[3] = '{psw_pkg::ADDR_GATE_B, 32'ha4c9, 32'h6453, 32'ha4c9};
      rows[4] = '{psw_pkg::ADDR_ORIGIN_B, 32'h0abc0def, 0, 32'h0abc0def};
      rows[5] = '{psw_pkg::ADDR_EXTENT_B, 32'h00100020, 0, 32'h00100020};
      rows[6] = '{20'h68078, '1, 0, 0};
      repeat (16) @(posedge i_mclk);
      #1 i_rst_n = 1'b1;
      foreach (rows[i]) rd(rows[i].a, rows[i].r);
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].d);
         rd(rows[i].a, rows[i].e);
      end
      cmp(o_armed, 2'h3);
      cmp(o_win_a, 64'h0);
      vb(2'h1);
      cmp(o_win_a, {13'h1fff, 12'h234, 13'h0123, 12'h456});
      cmp(o_gate_a, {3'h7, 3'h7, 2'h3, 2'h3, 2'h3});
      cmp(o_cyc_a, {11'h700, 11'h700, 10'h300, 10'h300, 10'h300});
      cmp(o_armed, 2'h2);
      cmp(o_win_b, 64'h0);
      vb(2'h2);
      cmp(o_win_b, {13'h0abc, 12'hdef, 13'h0010, 12'h020});
      cmp(o_gate_b, {3'h5, 3'h2, 2'h3, 2'h1, 2'h1});
      cmp(o_cyc_b, {11'h500, 11'h200, 10'h300, 10'h100, 10'h100});
      wr(psw_pkg::ADDR_ORIGIN_A, 32'h0);
      vb(2'h1);
      cmp(o_win_a, {13'h1fff, 12'h234, 13'h0123, 12'h456});
      // Enable low: the write and the vblank must both be ignored
      i_ce = 1'b0;
      wr(psw_pkg::ADDR_EXTENT_A, 32'h00300060);
      vb(2'h3);
      i_ce = 1'b1;
      cmp(o_armed, 2'h0);
      rd(psw_pkg::ADDR_EXTENT_A, 32'h01230456);
      wr(psw_pkg::ADDR_EXTENT_A, 32'h00300060);
      // Arming write in the vblank cycle: old values move, arm stays
      i_vblank_start = 2'h1;
      i_wr = 1'b1;
      i_addr = psw_pkg::ADDR_EXTENT_A;
      i_wdata = 32'h00500080;
      @(posedge i_mclk);
      #1 i_wr = 1'b0;
      i_vblank_start = 2'h0;
      cmp(o_win_a, {13'h0000, 12'h000, 13'h0030, 12'h060});
      @(posedge i_mclk);
      #1 cmp(o_armed, 2'h1);
      vb(2'h1);
      cmp(o_win_a, {13'h0000, 12'h000, 13'h0050, 12'h080});
      cmp(o_armed, 2'h0);
      i_rst_n = 1'b0;
      #40 cmp(o_gate_a, {3'h3, 3'h2, 2'h1, 2'h2, 2'h3});
      cmp(o_win_a, 64'h0);
      cmp(o_armed, 2'h0);
      print_verdict();
   end
   initial begin
      repeat (3000) @(posedge i_mclk);
      errors++;
      print_verdict();
   end
endmodule : psw_regs_tb_top
